// ===== design/sas_pkg.sv
// shared constants and types of the converter sequencer
package sas_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned NCH   = 8;   // single-ended inputs
  localparam int unsigned NPAIR = 4;   // differential pairs
  localparam int unsigned RES_W = 12;  // result width
  localparam int unsigned CH_W  = 3;   // channel number width
  localparam int unsigned NCMP  = 2;   // digital comparators
  localparam int unsigned NSTS  = 3;   // sticky status bits

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DATA0 = 8'h00;  // data 0..7 at 00..1C
  localparam logic [7:0] OFS_CTRL  = 8'h20;  // converter control
  localparam logic [7:0] OFS_CHEN  = 8'h24;  // channel enables
  localparam logic [7:0] OFS_CMP0  = 8'h28;  // comparator 0
  localparam logic [7:0] OFS_CMP1  = 8'h2C;  // comparator 1
  localparam logic [7:0] OFS_STAT  = 8'h30;  // sticky status, read only
  localparam logic [7:0] OFS_IE    = 8'h34;  // interrupt enable
  localparam logic [7:0] OFS_ICLR  = 8'h38;  // status clear, write only

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned DAT_OVR   = 16;  // overrun flag
  localparam int unsigned DAT_VLD   = 17;  // valid flag
  localparam int unsigned CTL_MODE  = 2;   // mode, two bits
  localparam int unsigned CTL_DIFF  = 4;   // differential pairs
  localparam int unsigned CTL_PWMEN = 6;   // pwm triggers allowed
  localparam int unsigned CTL_EXTEN = 7;   // start pin allowed
  localparam int unsigned CTL_START = 11;  // conversion start bit
  localparam int unsigned CHEN_BG   = 8;   // channel 7 on band-gap
  localparam int unsigned CMP_EN    = 0;   // comparator enable
  localparam int unsigned CMP_GE    = 1;   // 1: >=, 0: <
  localparam int unsigned CMP_CH    = 3;   // channel, three bits
  localparam int unsigned CMP_VAL   = 16;  // value, twelve bits
  localparam int unsigned STS_DONE  = 0;   // sequence finished
  localparam int unsigned STS_CMP0  = 1;   // comparator 0 hit
  localparam int unsigned STS_BUSY  = 8;   // live busy level

  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SCAN   = 2'h2;
  localparam logic [1:0] MODE_CONT   = 2'h3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [8:0]  CHEN_RST = 9'h000;
  localparam logic [31:0] CMP_RST  = 32'h0000_0000;
  localparam logic [2:0]  IE_RST   = 3'h0;

  // sequencer states
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT} sas_state_t;

endpackage

// ===== design/sas_cmp_if.sv
// bundle between the sequencer and one digital comparator
interface sas_cmp_if;
  logic [11:0] res;     // fresh result
  logic [2:0]  resCh;   // channel of that result
  logic        resStb;  // result stored this cycle
  logic        en;      // comparator enabled
  logic        ge;      // compare greater-or-equal
  logic [2:0]  ch;      // channel watched
  logic [11:0] val;     // programmed value
  logic        hit;     // match pulse

  // sequencer side
  modport ctl (output res, resCh, resStb, en, ge, ch, val, input hit);
  // comparator side
  modport cmp (input res, resCh, resStb, en, ge, ch, val, output hit);
endinterface

// ===== design/sas_cmp.sv
// one digital comparator on stored results
module sas_cmp (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clkEn,
  // sequencer link
  sas_cmp_if.cmp   cmpIf
);

  // ----------------------------------------
  // match decode
  // ----------------------------------------
  logic hit_q;    // registered match pulse
  logic hit_d;    // next match pulse
  logic cmpTrue;  // compare condition holds

  // greater-or-equal or strictly less
  assign cmpTrue = cmpIf.ge ? (cmpIf.res >= cmpIf.val) : (cmpIf.res < cmpIf.val);
  assign hit_d = cmpIf.resStb & cmpIf.en & (cmpIf.resCh == cmpIf.ch) & cmpTrue;
  assign cmpIf.hit = hit_q;

  // pulse register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hit_q <= 1'b0;
    end else if (clkEn) begin
      hit_q <= hit_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cmpHit;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && cmpIf.resStb && cmpIf.en && cmpIf.resCh == cmpIf.ch
       && cmpIf.ge && cmpIf.res >= cmpIf.val) |=> cmpIf.hit;
  endproperty
  a_cmpHit: assert property (p_cmpHit) else $error("comparator missed a match");

endmodule

// ===== design/sas_top.sv
// sequencer and register file around a 12-bit sar converter
// How it works
// - twelve-bit results, eight input channels
// - optional four differential pairs, one result each
// - single mode converts one channel, stops
// - scan converts enabled channels ascending once
// - continuous scan repeats until software stops
// - writing start bit one begins mode
// - pwm triggers also start the sequence
// - external start pin edge also starts
// - per-channel result with valid, overrun flags
// - two comparators raise enabled interrupts
// - channel seven selects pin or band-gap
module sas_top (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // converter core
  output logic             convStart,
  output logic      [2:0]  convChan,
  output logic             convDiff,
  output logic             convBandGap,
  input  wire logic        convDone,
  input  wire logic [11:0] convResult,
  // trigger sources
  input  wire logic        pwmTrig,
  input  wire logic        basicPwmTrig,
  input  wire logic        externalStartPin,
  // interrupt
  output logic             irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  sas_pkg::sas_state_t st_q;      // sequencer state
  sas_pkg::sas_state_t stD;       // next state
  logic [2:0]   chanQ;            // channel in conversion
  logic [2:0]   chanD;            // next channel
  logic [11:0]  ctrl_q;           // control register
  logic         startD;           // next start bit
  logic [8:0]   chen_q;           // channel enables, band-gap
  logic [31:0]  cmp_q [2];        // comparator settings
  logic [2:0]   stat_q;           // sticky status
  logic [2:0]   stat_d;           // next status
  logic [2:0]   ie_q;             // interrupt enables
  logic [11:0]  datRes_q [8];     // stored results
  logic [7:0]   vld_q;            // valid flags
  logic [7:0]   ovr_q;            // overrun flags
  logic [7:0]   vld_d;            // next valid flags
  logic [7:0]   ovr_d;            // next overrun flags
  logic [7:0]   rdDat;            // data register read now
  logic         wrPend_q;         // write data phase pending
  logic [7:0]   wAddr_q;          // write address
  logic [31:0]  hrdata_q;         // read data
  logic         hreadyout_q;      // ready out
  logic         convStart_q;      // start pulse to core
  logic         convBg_q;         // band-gap select
  logic         irq_q;            // interrupt level
  logic         extMeta_q;        // pin sync stage one
  logic         extSync_q;        // pin sync stage two
  logic         extPrev_q;        // pin edge history
  logic         store;            // result taken this cycle
  logic         doneEv;           // sequence end event
  logic         abort;            // software stop
  logic [1:0]   cmpHit;           // comparator pulses

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        accept   = hsel & htrans[1] & hready;
  wire        rdAcc    = accept & ~hwrite;
  wire        wrAcc    = accept & hwrite;
  wire [7:0]  rdAddr   = haddr[7:0];
  wire [2:0]  dataIdx  = rdAddr[4:2];
  wire        isData   = (rdAddr < sas_pkg::OFS_CTRL);
  wire        ctrlWr   = wrPend_q & (wAddr_q == sas_pkg::OFS_CTRL);
  wire        chenWr   = wrPend_q & (wAddr_q == sas_pkg::OFS_CHEN);
  wire        ieWr     = wrPend_q & (wAddr_q == sas_pkg::OFS_IE);
  wire        iclrWr   = wrPend_q & (wAddr_q == sas_pkg::OFS_ICLR);
  wire [1:0]  cmpWr    = {wrPend_q & (wAddr_q == sas_pkg::OFS_CMP1),
                          wrPend_q & (wAddr_q == sas_pkg::OFS_CMP0)};

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire [1:0]  mode     = ctrl_q[sas_pkg::CTL_MODE +: 2];
  wire        diffOn   = ctrl_q[sas_pkg::CTL_DIFF];
  // a control write's pair setting already governs the start it carries
  wire        diffNow  = ctrlWr ? hwdata[sas_pkg::CTL_DIFF] : diffOn;
  wire        busy     = (st_q != sas_pkg::S_IDLE);
  // pairs use only the low four enables
  wire [7:0]  effMask  = diffNow ? {4'h0, chen_q[3:0]} : chen_q[7:0];

  // ----------------------------------------
  // channel search
  // ----------------------------------------
  // lowest enabled channel above cur, or lowest overall
  function automatic logic [3:0] pickCh(input logic [7:0] m, input logic [2:0] cur,
                                        input logic anyCh);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (anyCh || i > int'(cur))) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  wire [3:0]  first    = pickCh(effMask, 3'h0, 1'b1);
  wire [3:0]  nxt      = pickCh(effMask, chanQ, 1'b0);
  wire        firstFnd = first[3];
  wire        nxtFnd   = nxt[3];

  // ----------------------------------------
  // start sources
  // ----------------------------------------
  // software writes one to the start bit
  wire        swGo     = ctrlWr & hwdata[sas_pkg::CTL_START];
  // rising edge of the synchronised pin
  wire        extRise  = extSync_q & ~extPrev_q;
  wire        hwGo     = (ctrl_q[sas_pkg::CTL_PWMEN] & (pwmTrig | basicPwmTrig))
                       | (ctrl_q[sas_pkg::CTL_EXTEN] & extRise);

  // start pin synchroniser and edge history
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      extMeta_q <= 1'b0;
      extSync_q <= 1'b0;
      extPrev_q <= 1'b0;
    end else if (clkEn) begin
      extMeta_q <= externalStartPin;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // software stop while busy
  assign abort = busy & ctrlWr & ~hwdata[sas_pkg::CTL_START];

  // next state, channel and start bit
  always_comb begin
    stD    = st_q;
    chanD  = chanQ;
    startD = ctrl_q[sas_pkg::CTL_START];
    doneEv = 1'b0;
    store  = 1'b0;
    case (st_q)
      // idle: wait for any start source
      sas_pkg::S_IDLE: begin
        startD = 1'b0;
        if (swGo | hwGo) begin
          if (firstFnd) begin
            stD    = sas_pkg::S_CONV;
            chanD  = first[2:0];
            startD = 1'b1;
          end else begin
            doneEv = 1'b1;
          end
        end
      end
      // start pulse stands one cycle
      sas_pkg::S_CONV: begin
        stD = sas_pkg::S_WAIT;
      end
      // wait for the core's result
      sas_pkg::S_WAIT: begin
        if (convDone) begin
          store = 1'b1;
          // climb to the next enabled channel
          if (mode != sas_pkg::MODE_SINGLE && nxtFnd) begin
            stD   = sas_pkg::S_CONV;
            chanD = nxt[2:0];
          end else if (mode == sas_pkg::MODE_CONT && firstFnd) begin
            stD    = sas_pkg::S_CONV;
            chanD  = first[2:0];
            doneEv = 1'b1;
          end else begin
            stD    = sas_pkg::S_IDLE;
            startD = 1'b0;
            doneEv = 1'b1;
          end
        end
      end
      default: begin
        stD    = sas_pkg::S_IDLE;
        startD = 1'b0;
      end
    endcase
    // a written zero while busy wins over next state and start bit
    if (abort) begin
      stD    = sas_pkg::S_IDLE;
      startD = 1'b0;
    end
  end

  // state, channel and core drive
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q        <= sas_pkg::S_IDLE;
      chanQ       <= 3'h0;
      convStart_q <= 1'b0;
      convBg_q    <= 1'b0;
    end else if (clkEn) begin
      st_q        <= stD;
      chanQ       <= chanD;
      convStart_q <= (stD == sas_pkg::S_CONV);
      convBg_q    <= chen_q[sas_pkg::CHEN_BG] & ~diffNow & (chanD == 3'h7);
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  genvar g;
  for (g = 0; g < 8; g++) begin : gDat
    wire hitCh = store & (chanQ == 3'(g));
    assign rdDat[g] = rdAcc & isData & (dataIdx == 3'(g));
    // new result wins over a read clear
    assign vld_d[g] = hitCh | (vld_q[g] & ~rdDat[g]);
    assign ovr_d[g] = (hitCh & vld_q[g] & ~rdDat[g]) | (ovr_q[g] & ~rdDat[g]);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vld_q <= 8'h00;
      ovr_q <= 8'h00;
    end else if (clkEn) begin
      vld_q <= vld_d;
      ovr_q <= ovr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clkEn && store) begin
      datRes_q[chanQ] <= convResult;
    end
  end

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  sas_cmp_if cmpIf [2] ();
  for (g = 0; g < 2; g++) begin : gCmp
    assign cmpIf[g].res    = convResult;
    assign cmpIf[g].resCh  = chanQ;
    assign cmpIf[g].resStb = store;
    assign cmpIf[g].en     = cmp_q[g][sas_pkg::CMP_EN];
    assign cmpIf[g].ge     = cmp_q[g][sas_pkg::CMP_GE];
    assign cmpIf[g].ch     = cmp_q[g][sas_pkg::CMP_CH +: 3];
    assign cmpIf[g].val    = cmp_q[g][sas_pkg::CMP_VAL +: 12];
    assign cmpHit[g]       = cmpIf[g].hit;
    sas_cmp uCmp (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clkEn   (clkEn),
      .cmpIf   (cmpIf[g])
    );
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // set wins over a same-cycle clear
  assign stat_d = (stat_q & ~(iclrWr ? hwdata[2:0] : 3'h0)) | {cmpHit, doneEv};

  // control, enables, comparator settings, status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= sas_pkg::CTRL_RST;
      chen_q <= sas_pkg::CHEN_RST;
      cmp_q  <= '{sas_pkg::CMP_RST, sas_pkg::CMP_RST};
      ie_q   <= sas_pkg::IE_RST;
      stat_q <= 3'h0;
      irq_q  <= 1'b0;
    end else if (clkEn) begin
      ctrl_q <= {startD, ctrlWr ? hwdata[10:0] : ctrl_q[10:0]};
      for (int k = 0; k < 2; k++) begin
        if (cmpWr[k]) begin
          cmp_q[k] <= hwdata;
        end
      end
      if (chenWr) begin
        chen_q <= hwdata[8:0];
      end
      if (ieWr) begin
        ie_q <= hwdata[2:0];
      end
      stat_q <= stat_d;
      irq_q  <= |(stat_q & ie_q);
    end
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  wire [31:0] datWord = {14'h0, vld_q[dataIdx], ovr_q[dataIdx], 4'h0, datRes_q[dataIdx]};
  wire [31:0] rdMux =
      isData                          ? datWord :
      (rdAddr == sas_pkg::OFS_CTRL)   ? {20'h0, ctrl_q} :
      (rdAddr == sas_pkg::OFS_CHEN)   ? {23'h0, chen_q} :
      (rdAddr == sas_pkg::OFS_CMP0)   ? cmp_q[0] :
      (rdAddr == sas_pkg::OFS_CMP1)   ? cmp_q[1] :
      (rdAddr == sas_pkg::OFS_STAT)   ? {23'h0, busy, 5'h0, stat_q} :
      (rdAddr == sas_pkg::OFS_IE)     ? {29'h0, ie_q} : 32'h0000_0000;

  // address phase capture; zero wait states
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPend_q    <= 1'b0;
      wAddr_q     <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else if (clkEn) begin
      wrPend_q    <= wrAcc;
      wAddr_q     <= rdAddr;
      hreadyout_q <= 1'b1;
      if (rdAcc) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // outputs straight from flops, hresp tied low
  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = 1'b0;
  assign convStart   = convStart_q;
  assign convChan    = chanQ;
  assign convDiff    = ctrl_q[sas_pkg::CTL_DIFF];
  assign convBandGap = convBg_q;
  assign irq         = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_swStart;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && !busy && swGo && firstFnd) |=> convStart ##1 (st_q == sas_pkg::S_WAIT);
  endproperty
  a_swStart: assert property (p_swStart) else $error("software start lost");

  property p_pwmStart;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && !busy && ctrl_q[sas_pkg::CTL_PWMEN] && pwmTrig && firstFnd)
      |=> convStart && ctrl_q[sas_pkg::CTL_START];
  endproperty
  a_pwmStart: assert property (p_pwmStart) else $error("pwm trigger lost");

  property p_extStart;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && !busy && ctrl_q[sas_pkg::CTL_EXTEN] && extRise && firstFnd) |=> convStart;
  endproperty
  a_extStart: assert property (p_extStart) else $error("pin start lost");

  property p_single;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && store && mode == sas_pkg::MODE_SINGLE && !abort)
      |=> !busy && !ctrl_q[sas_pkg::CTL_START] && stat_q[sas_pkg::STS_DONE];
  endproperty
  a_single: assert property (p_single) else $error("single mode did not stop");

  property p_ascend;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && store && mode != sas_pkg::MODE_SINGLE && nxtFnd && !abort)
      |=> convStart && (chanQ > $past(chanQ));
  endproperty
  a_ascend: assert property (p_ascend) else $error("scan order broken");

  property p_wrap;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && store && mode == sas_pkg::MODE_CONT && !nxtFnd && firstFnd && !abort)
      |=> convStart && ctrl_q[sas_pkg::CTL_START];
  endproperty
  a_wrap: assert property (p_wrap) else $error("continuous scan paused");

  property p_stop;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && abort) |=> !busy && !convStart && !ctrl_q[sas_pkg::CTL_START];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");

  property p_store;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && store) |=> vld_q[$past(chanQ)] && datRes_q[$past(chanQ)] == $past(convResult);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_ovr;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && store && vld_q[chanQ] && !rdDat[chanQ]) |=> ovr_q[$past(chanQ)];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");

  property p_diff;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && stD == sas_pkg::S_CONV) |=> (!convDiff || convChan < 3'h4);
  endproperty
  a_diff: assert property (p_diff) else $error("pair index out of range");

  property p_bandGap;
    @(posedge ref_clk) disable iff (srst)
      convBandGap |-> convChan == 3'h7;
  endproperty
  a_bandGap: assert property (p_bandGap) else $error("band-gap on wrong channel");

  property p_irq;
    @(posedge ref_clk) disable iff (srst)
      (clkEn && (stat_q & ie_q) != 3'h0) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// ===== tb/sas_core_model.sv
// behavioural model of the analog converter core
module sas_core_model (
  // clock and pacing
  input  wire logic        ref_clk,
  input  wire logic        slow,
  // converter link
  input  wire logic        convStart,
  input  wire logic [2:0]  convChan,
  output logic             convDone,
  output logic      [11:0] convResult
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;  // cycles left in conversion
  initial convDone = 1'b0;
  initial convResult = 12'h000;
  always @(posedge ref_clk) begin
    convDone   <= 1'b0;
    convResult <= ~convResult;  // no stale value outside done
    if (convStart) cnt <= slow ? 6 : 1;
    else if (cnt == 1) begin
      convDone   <= 1'b1;
      convResult <= {1'b0, convChan, 8'hA5};
      cnt        <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// ===== tb/sas_top_tb.sv
// self-checking bench of the converter sequencer
module sas_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        ref_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, clkEn = 1'b1;
  logic        hready, hreadyout, hresp, convStart, convDiff, convBandGap, convDone, irq;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [2:0]  convChan;
  logic [11:0] convResult;
  logic        pwmTrig = 1'b0, basicPwmTrig = 1'b0, externalStartPin = 1'b0;
  logic [4:0]  seen[$];  // {diff, bandgap, channel} per start
  int          n_errors = 0, comparisons = 0, cycles = 0;
  assign hready = hreadyout;
  always #10 ref_clk = ~ref_clk;
  sas_top dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .convStart(convStart), .convChan(convChan), .convDiff(convDiff), .convBandGap(convBandGap),
    .convDone(convDone), .convResult(convResult), .pwmTrig(pwmTrig), .basicPwmTrig(basicPwmTrig),
    .externalStartPin(externalStartPin), .irq(irq));
  sas_core_model core (.ref_clk(ref_clk), .slow(slow), .convStart(convStart), .convChan(convChan),
    .convDone(convDone), .convResult(convResult));
  // log each start, cut a hang short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (convStart === 1'b1) seen.push_back({convDiff, convBandGap, convChan});
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer, held until hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask
  // poll busy until the sequence ends
  task automatic wait_idle();
    logic [31:0] r;
    repeat (2) @(posedge ref_clk);
    do bus(sas_pkg::OFS_STAT, 1'b0, 32'h0, r); while (r[sas_pkg::STS_BUSY] !== 1'b0);
  endtask
  function automatic logic [31:0] dat(input logic [2:0] c, input logic v, input logic o);
    return {14'h0, v, o, 4'h0, 1'b0, c, 8'hA5};
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(sas_pkg::OFS_CTRL, 32'h0);
    chk(hresp, 1'b0);
    rd(sas_pkg::OFS_CHEN, 32'h0);
    rd(sas_pkg::OFS_STAT, 32'h0);
    rd(sas_pkg::OFS_IE, 32'h0);
    rd(sas_pkg::OFS_ICLR, 32'h0);
    rd(8'h3C, 32'h0);
  endtask
  task automatic t_single();
    wr(sas_pkg::OFS_CHEN, 32'h0A);
    seen.delete();
    wr(sas_pkg::OFS_CTRL, 32'h800);
    wait_idle();
    chk({seen.size(), seen[0]}, {32'h1, 5'h01});
    rd(sas_pkg::OFS_CTRL, 32'h0);
    rd(8'h04, dat(3'h1, 1'b1, 1'b0));
    rd(8'h04, dat(3'h1, 1'b0, 1'b0));
  endtask
  task automatic t_scan();
    slow <= 1'b1;
    seen.delete();
    wr(sas_pkg::OFS_CTRL, 32'h808);
    wait_idle();
    wr(sas_pkg::OFS_CTRL, 32'h808);
    wait_idle();
    chk({seen.size(), seen[0], seen[1], seen[2], seen[3]}, {32'h4, 20'h08C23});
    rd(8'h0C, dat(3'h3, 1'b1, 1'b1));
    rd(sas_pkg::OFS_CTRL, 32'h8);
    slow <= 1'b0;
  endtask
  task automatic t_cont();
    int n;
    seen.delete();
    wr(sas_pkg::OFS_CTRL, 32'h80C);
    repeat (60) @(posedge ref_clk);
    wr(sas_pkg::OFS_CTRL, 32'h00C);
    @(posedge ref_clk);
    n = seen.size();
    repeat (20) @(posedge ref_clk);
    chk({seen.size(), 31'h0, n > 8}, {n, 32'h1});
    for (int i = 0; i < n; i++) chk(seen[i], (i % 2) ? 5'h03 : 5'h01);
    rd(sas_pkg::OFS_CTRL, 32'hC);
  endtask
  task automatic t_trig();
    wr(sas_pkg::OFS_CTRL, 32'h0);
    seen.delete();
    pwmTrig <= 1'b1;
    @(posedge ref_clk);
    pwmTrig <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(seen.size(), 0);
    wr(sas_pkg::OFS_CTRL, 32'h40);
    clkEn <= 1'b0;
    pwmTrig <= 1'b1;
    @(posedge ref_clk);
    pwmTrig <= 1'b0;
    clkEn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(seen.size(), 0);  // frozen while the enable is low
    pwmTrig <= 1'b1;
    @(posedge ref_clk);
    pwmTrig <= 1'b0;
    wait_idle();
    basicPwmTrig <= 1'b1;
    @(posedge ref_clk);
    basicPwmTrig <= 1'b0;
    wait_idle();
    wr(sas_pkg::OFS_CTRL, 32'h80);
    externalStartPin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    externalStartPin <= 1'b0;
    wait_idle();
    chk(seen.size(), 3);
  endtask
  task automatic t_modes();
    wr(sas_pkg::OFS_CHEN, 32'h180);
    seen.delete();
    wr(sas_pkg::OFS_CTRL, 32'h800);
    wait_idle();
    wr(sas_pkg::OFS_CHEN, 32'h8A);
    wr(sas_pkg::OFS_CTRL, 32'h818);
    wait_idle();
    chk({seen.size(), seen[0], seen[1], seen[2]}, {32'h3, 15'h3E33});
  endtask
  task automatic t_irq();
    wr(sas_pkg::OFS_ICLR, 32'h7);
    wr(sas_pkg::OFS_IE, 32'h2);
    wr(sas_pkg::OFS_CMP0, 32'h0B);
    wr(sas_pkg::OFS_CHEN, 32'h2);
    wr(sas_pkg::OFS_CTRL, 32'h800);
    wait_idle();
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    rd(sas_pkg::OFS_STAT, 32'h3);
    rd(sas_pkg::OFS_CMP0, 32'h0B);
    wr(sas_pkg::OFS_ICLR, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    wr(sas_pkg::OFS_IE, 32'h0);
    wr(sas_pkg::OFS_CMP1, 32'h01A6_0009);
    wr(sas_pkg::OFS_CTRL, 32'h800);
    wait_idle();
    chk(irq, 1'b0);
    rd(sas_pkg::OFS_STAT, 32'h7);
  endtask
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_cont();
    t_trig();
    t_modes();
    t_irq();
    complete_run();
  end
endmodule
